// ---- ssx_pkg.sv ----
package ssx_pkg;

  // =========================================================
  // operation codes
  typedef enum logic [2:0] {
    SSX_OP_NONE,
    SSX_OP_SUBLIT,
    SSX_OP_SUBBOR,
    SSX_OP_SWAP,
    SSX_OP_DIRLOAD,
    SSX_OP_XORLIT,
    SSX_OP_XORFILE
  } ssx_op_e;

  // =========================================================
  // register map
  localparam logic [31:0] SSX_ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] SSX_ADDR_OPER   = 32'h0000_0004;
  localparam logic [31:0] SSX_ADDR_WREG   = 32'h0000_0008;
  localparam logic [31:0] SSX_ADDR_STATUS = 32'h0000_000C;
  localparam logic [31:0] SSX_ADDR_DIR    = 32'h0000_0010;
  localparam logic [31:0] SSX_ADDR_FILE   = 32'h0000_0200;

  // field layout of the operand register
  localparam int SSX_LIT_LSB  = 0;
  localparam int SSX_FA_LSB   = 8;
  localparam int SSX_DEST_BIT = 16;
  // status bits
  localparam int SSX_C_BIT  = 0;
  localparam int SSX_DC_BIT = 1;
  localparam int SSX_Z_BIT  = 2;

  // direction-load operand values
  localparam logic [6:0] SSX_DIR_A = 7'h05;
  localparam logic [6:0] SSX_DIR_B = 7'h06;
  localparam logic [6:0] SSX_DIR_C = 7'h07;

  localparam logic [7:0] SSX_DIR_RESET = 8'hFF;
  localparam int         SSX_FILE_DEPTH = 128;
  localparam logic [1:0] SSX_HTRANS_NONSEQ = 2'h2;

endpackage

// ---- ssx_file_mem.sv ----
`timescale 1ns/100ps
module ssx_file_mem
  import ssx_pkg::*;
(
  // clock
  input  wire logic       sys_clk,
  // write port
  input  wire logic       wrEn,
  input  wire logic [6:0] wrAddr,
  input  wire logic [7:0] wrData,
  // read port, registered
  input  wire logic [6:0] rdAddr,
  output logic      [7:0] rdData
);

  logic [7:0] memArray [SSX_FILE_DEPTH];

  // =========================================================
  // storage; no reset so it maps to ram
  always_ff @(posedge sys_clk)
  begin
    if (wrEn)
    begin
      memArray[wrAddr] <= wrData;
    end
    rdData <= memArray[rdAddr];
  end

endmodule // ssx_file_mem

// ---- ssx_exec.sv ----
// Function
// - literal minus working register, result into working register
// - carry set unless working value exceeds literal, digit carry unless working low nibble exceeds literal low nibble
// - file minus working minus inverted carry, updating carry, digit carry, zero
// - file operands: 7-bit address, destination 0 working, 1 file
// - nibble swap of file register into destination, flags untouched
// - operand 5,6,7 copies working register to direction A,B,C
// - xor literal with working register into working, zero only
// - xor file with working, routed by destination, zero only
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
module ssx_exec
  import ssx_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // direction outputs
  output logic      [7:0]  port_a_direction,
  output logic      [7:0]  port_b_direction,
  output logic      [7:0]  port_c_direction,
  // flags
  output logic             carryFlag,
  output logic             digit_carry_flag,
  output logic             zeroFlag,
  output logic             busy
);

  typedef enum logic [1:0] {SSX_IDLE, SSX_FETCH, SSX_EXEC} ssx_state_e;

  // =========================================================
  // arithmetic helper: a - b - borrow, nine bits with carry out
  function automatic logic [8:0] ssxSub(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin);
    ssxSub = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
  endfunction

  function automatic logic [4:0] ssxSubLow(input logic [3:0] a, input logic [3:0] b,
                                           input logic cin);
    ssxSubLow = {1'b0, a} + {1'b0, ~b} + {4'h0, cin};
  endfunction

  // =========================================================
  // bus address phase capture
  logic        phValid_reg, phValid_next;
  logic        phWrite_reg, phWrite_next;
  logic [31:0] phAddr_reg, phAddr_next;
  logic        addrPhase;

  assign addrPhase = hsel && hready && (htrans == SSX_HTRANS_NONSEQ);

  always_comb
  begin
    phValid_next = phValid_reg;
    phWrite_next = phWrite_reg;
    phAddr_next  = phAddr_reg;
    if (hready)
    begin
      phValid_next = addrPhase;
      phWrite_next = hwrite;
      phAddr_next  = haddr;
    end
  end

  // =========================================================
  // architectural state
  ssx_state_e  state_reg, state_next;
  ssx_op_e     op_reg, op_next;
  logic [7:0]  wReg_reg, wReg_next;
  logic [7:0]  lit_reg, lit_next;
  logic [6:0]  fa_reg, fa_next;
  logic        dest_reg, dest_next;
  logic        c_reg, c_next;
  logic        dc_reg, dc_next;
  logic        z_reg, z_next;
  logic [7:0]  dirA_reg, dirA_next;
  logic [7:0]  dirB_reg, dirB_next;
  logic [7:0]  dirC_reg, dirC_next;

  logic        memWrEn;
  logic [6:0]  memWrAddr;
  logic [7:0]  memWrData;
  logic [6:0]  memRdAddr;
  logic [7:0]  memRdData;

  logic        dataWr;
  logic        fileHit;
  logic [8:0]  subFull;
  logic [4:0]  subLow;
  logic [7:0]  result;

  assign dataWr  = phValid_reg && phWrite_reg;
  assign fileHit = (phAddr_reg[31:9] == SSX_ADDR_FILE[31:9]);

  ssx_file_mem uFileMem (
    .sys_clk (sys_clk),
    .wrEn    (memWrEn),
    .wrAddr  (memWrAddr),
    .wrData  (memWrData),
    .rdAddr  (memRdAddr),
    .rdData  (memRdData)
  );

  // file array sits at 0x200..0x3FC, one byte per word, so haddr[8:2] is the index
  assign memRdAddr = (state_reg == SSX_IDLE && addrPhase) ? haddr[8:2] : fa_reg;

  always_comb
  begin
    state_next = state_reg;
    op_next    = op_reg;
    wReg_next  = wReg_reg;
    lit_next   = lit_reg;
    fa_next    = fa_reg;
    dest_next  = dest_reg;
    c_next     = c_reg;
    dc_next    = dc_reg;
    z_next     = z_reg;
    dirA_next  = dirA_reg;
    dirB_next  = dirB_reg;
    dirC_next  = dirC_reg;
    memWrEn    = 1'b0;
    memWrAddr  = phAddr_reg[8:2];
    memWrData  = hwdata[7:0];
    subFull    = 9'h000;
    subLow     = 5'h00;
    result     = 8'h00;
    case (state_reg)
      SSX_IDLE:
      begin
        if (dataWr)
        begin
          if (fileHit)
          begin
            memWrEn = 1'b1;
          end
          else if (phAddr_reg == SSX_ADDR_OPER)
          begin
            lit_next  = hwdata[SSX_LIT_LSB +: 8];
            fa_next   = hwdata[SSX_FA_LSB +: 7];
            dest_next = hwdata[SSX_DEST_BIT];
          end
          else if (phAddr_reg == SSX_ADDR_WREG)
          begin
            wReg_next = hwdata[7:0];
          end
          else if (phAddr_reg == SSX_ADDR_STATUS)
          begin
            c_next  = hwdata[SSX_C_BIT];
            dc_next = hwdata[SSX_DC_BIT];
            z_next  = hwdata[SSX_Z_BIT];
          end
          else if (phAddr_reg == SSX_ADDR_CTRL)
          begin
            op_next = ssx_op_e'(hwdata[2:0]);
            if (op_next != SSX_OP_NONE)
            begin
              state_next = SSX_FETCH;
            end
          end
        end
      end
      // one cycle for the registered file read
      SSX_FETCH:
      begin
        state_next = SSX_EXEC;
      end
      SSX_EXEC:
      begin
        state_next = SSX_IDLE;
        case (op_reg)
          SSX_OP_SUBLIT:
          begin
            subFull   = ssxSub(lit_reg, wReg_reg, 1'b1);
            subLow    = ssxSubLow(lit_reg[3:0], wReg_reg[3:0], 1'b1);
            result    = subFull[7:0];
            wReg_next = result;
            c_next    = subFull[8];
            dc_next   = subLow[4];
            z_next    = (result == 8'h00);
          end
          SSX_OP_SUBBOR:
          begin
            // carry in is the inverted borrow
            subFull = ssxSub(memRdData, wReg_reg, c_reg);
            subLow  = ssxSubLow(memRdData[3:0], wReg_reg[3:0], c_reg);
            result  = subFull[7:0];
            c_next  = subFull[8];
            dc_next = subLow[4];
            z_next  = (result == 8'h00);
          end
          SSX_OP_SWAP:
          begin
            result = {memRdData[3:0], memRdData[7:4]};
          end
          SSX_OP_DIRLOAD:
          begin
            // other operand values are ignored
            if (fa_reg == SSX_DIR_A) dirA_next = wReg_reg;
            if (fa_reg == SSX_DIR_B) dirB_next = wReg_reg;
            if (fa_reg == SSX_DIR_C) dirC_next = wReg_reg;
          end
          SSX_OP_XORLIT:
          begin
            result    = wReg_reg ^ lit_reg;
            wReg_next = result;
            z_next    = (result == 8'h00);
          end
          SSX_OP_XORFILE:
          begin
            result = wReg_reg ^ memRdData;
            z_next = (result == 8'h00);
          end
          default:
          begin
          end
        endcase
        // destination routing for file-operand ops
        if (op_reg == SSX_OP_SUBBOR || op_reg == SSX_OP_SWAP || op_reg == SSX_OP_XORFILE)
        begin
          if (dest_reg)
          begin
            memWrEn   = 1'b1;
            memWrAddr = fa_reg;
            memWrData = result;
          end
          else
          begin
            wReg_next = result;
          end
        end
      end
      default:
      begin
        state_next = SSX_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      phValid_reg <= 1'b0;
      phWrite_reg <= 1'b0;
      phAddr_reg  <= 32'h0000_0000;
      state_reg   <= SSX_IDLE;
      op_reg      <= SSX_OP_NONE;
      wReg_reg    <= 8'h00;
      lit_reg     <= 8'h00;
      fa_reg      <= 7'h00;
      dest_reg    <= 1'b0;
      c_reg       <= 1'b0;
      dc_reg      <= 1'b0;
      z_reg       <= 1'b0;
      dirA_reg    <= SSX_DIR_RESET;
      dirB_reg    <= SSX_DIR_RESET;
      dirC_reg    <= SSX_DIR_RESET;
    end
    else
    begin
      phValid_reg <= phValid_next;
      phWrite_reg <= phWrite_next;
      phAddr_reg  <= phAddr_next;
      state_reg   <= state_next;
      op_reg      <= op_next;
      wReg_reg    <= wReg_next;
      lit_reg     <= lit_next;
      fa_reg      <= fa_next;
      dest_reg    <= dest_next;
      c_reg       <= c_next;
      dc_reg      <= dc_next;
      z_reg       <= z_next;
      dirA_reg    <= dirA_next;
      dirB_reg    <= dirB_next;
      dirC_reg    <= dirC_next;
    end
  end

  // =========================================================
  // read mux; bus stalls while an operation runs
  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (phValid_reg && !phWrite_reg)
    begin
      if (fileHit)                             hrdata = {24'h000000, memRdData};
      else if (phAddr_reg == SSX_ADDR_CTRL)    hrdata = {29'h0, op_reg};
      else if (phAddr_reg == SSX_ADDR_OPER)    hrdata = {15'h0, dest_reg, 1'b0, fa_reg, lit_reg};
      else if (phAddr_reg == SSX_ADDR_WREG)    hrdata = {24'h000000, wReg_reg};
      else if (phAddr_reg == SSX_ADDR_STATUS)  hrdata = {29'h0, z_reg, dc_reg, c_reg};
      else if (phAddr_reg == SSX_ADDR_DIR)     hrdata = {8'h00, dirC_reg, dirB_reg, dirA_reg};
    end
  end

  assign hreadyout        = (state_reg == SSX_IDLE);
  assign hresp            = 1'b0;
  assign busy             = (state_reg != SSX_IDLE);
  assign port_a_direction = dirA_reg;
  assign port_b_direction = dirB_reg;
  assign port_c_direction = dirC_reg;
  assign carryFlag        = c_reg;
  assign digit_carry_flag = dc_reg;
  assign zeroFlag         = z_reg;

endmodule // ssx_exec

// ---- ssx_exec_assertions.sv ----
`timescale 1ns/100ps
module ssx_exec_checker
  import ssx_pkg::*;
(
  // clock, reset, bus
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // results
  input wire logic [7:0]  port_a_direction,
  input wire logic [7:0]  port_b_direction,
  input wire logic [7:0]  port_c_direction,
  input wire logic        carryFlag,
  input wire logic        digit_carry_flag,
  input wire logic        zeroFlag,
  input wire logic        busy
);
  // ==========================================================
  // helper: which write is in its data phase, last op code
  logic       ctlWr_reg;
  logic       stWr_reg;
  logic [2:0] op_reg;
  logic       wrReq;
  logic [2:0] flags;
  logic [23:0] dirs;
  assign wrReq = hsel && hready && htrans == SSX_HTRANS_NONSEQ && hwrite;
  assign flags = {zeroFlag, digit_carry_flag, carryFlag};
  assign dirs  = {port_c_direction, port_b_direction, port_a_direction};
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      ctlWr_reg <= 1'b0;
      stWr_reg  <= 1'b0;
      op_reg    <= 3'h0;
    end
    else if (hready)
    begin
      ctlWr_reg <= wrReq && haddr == SSX_ADDR_CTRL;
      stWr_reg  <= wrReq && haddr == SSX_ADDR_STATUS;
      op_reg    <= ctlWr_reg ? hwdata[2:0] : op_reg;
    end
  // ==========================================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_busy_inverse: assert property (busy == !hreadyout)
    else $error("busy disagrees with ready");
  a_stall_two: assert property ($fell(hreadyout) |-> ##1 !hreadyout ##1 hreadyout)
    else $error("operation stall not two cycles");
  a_stall_cause: assert property ($fell(hreadyout) |-> $past(ctlWr_reg))
    else $error("stall without control write");
  a_flag_cause: assert property (!$stable(flags) |-> $rose(hreadyout) || $past(stWr_reg))
    else $error("flags moved without cause");
  a_swap_keeps: assert property ($rose(hreadyout) && op_reg inside {3'h3, 3'h4} |-> $stable(flags))
    else $error("swap or direction load moved flags");
  a_xor_keeps: assert property ($rose(hreadyout) && op_reg inside {3'h5, 3'h6}
    |-> $stable(flags[1:0]))
    else $error("xor moved carry flags");
  a_dir_only: assert property (!$stable(dirs) |-> $rose(hreadyout) && op_reg == 3'h4)
    else $error("direction changed outside load");
endmodule // ssx_exec_checker

bind ssx_exec ssx_exec_checker chk_u (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
  .port_c_direction(port_c_direction), .carryFlag(carryFlag),
  .digit_carry_flag(digit_carry_flag), .zeroFlag(zeroFlag), .busy(busy));

// ---- ssx_exec_test.sv ----
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin fail_count++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end
module ssx_exec_test;
  import ssx_pkg::*;
  // ==========================================================
  // stimulus and model state
  logic        sysClk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hrdy, hresp, busy, cF, dcF, zF;
  logic [7:0]  dA, dB, dC;
  int          fail_count = 0, compares = 0, cyc = 0;
  int          w, c, dc, z, st, da = 255, db = 255, dcc = 255;
  int          lit, fa, d, fv, r, code, sub, hs;

  always #10 sysClk = ~sysClk;
  // hang guard, well above the expected few thousand cycles
  always @(posedge sysClk)
    if (++cyc == 30000)
    begin
      fail_count++;
      results();
    end

  ssx_exec dut_u (.sys_clk(sysClk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
    .hreadyout(hrdy), .hresp(hresp), .port_a_direction(dA), .port_b_direction(dB),
    .port_c_direction(dC), .carryFlag(cF), .digit_carry_flag(dcF), .zeroFlag(zF), .busy(busy));

  // ==========================================================
  // bus tasks: entered just after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] a, dat);
    hsel <= 1'b1;
    htrans <= SSX_HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= a;
    do @(posedge sysClk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dat;
    do @(posedge sysClk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] a, ex);
    xfer(1'b0, a, 32'h0);
    `CHK(nm, ex, rd)
  endtask

  // ==========================================================
  // one random operation against the model
  task automatic run_op();
    code = $urandom_range(6);
    lit = $urandom_range(255);
    fa = $urandom_range(127);
    d = $urandom_range(1);
    st = $urandom_range(7);
    // equal operands hit the borrow boundary often
    w = $urandom_range(2) == 0 ? lit : $urandom_range(255);
    fv = $urandom_range(2) == 0 ? w : $urandom_range(255);
    if (code == 4 && d == 1)
      fa = 5 + $urandom_range(2);
    c = st & 1;
    dc = (st >> 1) & 1;
    z = st >> 2;
    xfer(1'b1, SSX_ADDR_WREG, w);
    xfer(1'b1, SSX_ADDR_STATUS, st);
    xfer(1'b1, SSX_ADDR_FILE + 4 * fa, fv);
    xfer(1'b1, SSX_ADDR_OPER, lit | fa << 8 | d << 16);
    xfer(1'b1, SSX_ADDR_CTRL, code);
    sub = code == 1 ? lit - w : fv - w - (1 - c);
    hs = code == 1 ? (lit & 15) - (w & 15) : (fv & 15) - (w & 15) - (1 - c);
    r = code < 3 ? sub & 255 : code == 3 ? ((fv << 4) | (fv >> 4)) & 255
      : code == 5 ? w ^ lit : w ^ fv;
    if (code inside {1, 2})
      c = sub >= 0;
    if (code inside {1, 2})
      dc = hs >= 0;
    if (code inside {1, 2, 5, 6})
      z = r == 0;
    if (code == 4 && fa == 5)
      da = w;
    if (code == 4 && fa == 6)
      db = w;
    if (code == 4 && fa == 7)
      dcc = w;
    if (code inside {1, 5} || (code inside {2, 3, 6} && d == 0))
      w = r;
    else if (code inside {2, 3, 6})
      fv = r;
    chk("wreg", SSX_ADDR_WREG, w);
    chk("file", SSX_ADDR_FILE + 4 * fa, fv);
    chk("status", SSX_ADDR_STATUS, z * 4 + dc * 2 + c);
    chk("dir", SSX_ADDR_DIR, dcc << 16 | db << 8 | da);
    `CHK("flags", 3'(z * 4 + dc * 2 + c), {zF, dcF, cF})
    `CHK("dirPins", 24'(dcc << 16 | db << 8 | da), {dC, dB, dA})
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    void'($urandom(32'h147CD829));
    repeat (12) @(posedge sysClk);
    rst <= 1'b0;
    `CHK("dirReset", 24'hFFFFFF, {dC, dB, dA})
    `CHK("flagReset", 3'h0, {zF, dcF, cF})
    $display("reset test done");
    xfer(1'b1, 32'h400, 32'hFFFFFFFF);
    chk("unmapped", 32'h400, 32'h0);
    $display("unmapped test done");
    repeat (150) run_op();
    $display("operation test done");
    // reset again in mid-run, bus idle
    rst <= 1'b1;
    @(posedge sysClk);
    rst <= 1'b0;
    da = 255;
    db = 255;
    dcc = 255;
    `CHK("dirRearm", 24'hFFFFFF, {dC, dB, dA})
    `CHK("flagRearm", 3'h0, {zF, dcF, cF})
    chk("wregRearm", SSX_ADDR_WREG, 32'h0);
    repeat (20) run_op();
    $display("second reset test done");
    results();
  end
endmodule // ssx_exec_test
